// File: pcd_defs.svh
`ifndef PCD_DEFS_SVH
`define PCD_DEFS_SVH
// register offsets
`define PCD_OFS_DELAY_CH1     8'h11
`define PCD_OFS_DELAY_CH2     8'h12
`define PCD_OFS_DELAY_CH1_INV 8'h13
`define PCD_OFS_DELAY_CH2_INV 8'h14
`define PCD_OFS_SYS_CTRL      8'h05
`define PCD_OFS_GROUP_MASK    8'h19
`define PCD_OFS_START_STOP    8'h1a
// reset values
`define PCD_RST_DELAY_ODD     8'hac
`define PCD_RST_DELAY_EVEN    8'h54
`define PCD_RST_SYS_CTRL      8'h40
`define PCD_RST_GROUP_MASK    8'h30
`define PCD_RST_START_STOP    8'h0f
// field positions
`define PCD_DELAY_MSB         7
`define PCD_DELAY_LSB         2
`define PCD_SHUTDOWN_BIT      6
`define PCD_GROUP_EN_BIT      5
`define PCD_TIMER_OFF_BIT     7
`define PCD_PERIOD_MSB        4
// timing: one delay step is four delay-clock cycles
`define PCD_DELAY_STEP        4
// hold table unit: one tenth of a millisecond, given in microseconds
`define PCD_HOLD_UNIT_US      100
// hold length per period code, in tenths of a millisecond
`define PCD_HOLD_08           18'h000a5
`define PCD_HOLD_09           18'h000ef
`define PCD_HOLD_0A           18'h0013a
`define PCD_HOLD_0B           18'h00194
`define PCD_HOLD_0C           18'h0021b
`define PCD_HOLD_0D           18'h002bf
`define PCD_HOLD_0E           18'h003ae
`define PCD_HOLD_0F           18'h004e9
`define PCD_HOLD_10           18'h0066e
`define PCD_HOLD_11           18'h0095a
`define PCD_HOLD_12           18'h00c46
`define PCD_HOLD_13           18'h00fc7
`define PCD_HOLD_14           18'h0150a
`define PCD_HOLD_15           18'h01b77
`define PCD_HOLD_16           18'h024d1
`define PCD_HOLD_17           18'h03116
`define PCD_HOLD_18           18'h04381
`define PCD_HOLD_19           18'h06230
`define PCD_HOLD_1A           18'h080df
`define PCD_HOLD_1B           18'h0a5b1
`define PCD_HOLD_1C           18'h0dcec
`define PCD_HOLD_1D           18'h1206d
`define PCD_HOLD_1E           18'h1829d
`define PCD_HOLD_1F           18'h2037c
`define PCD_CLK_MHZ           40
`endif

// File: pcd_pkg.sv
package pcd_pkg;
  typedef enum logic [1:0] {
    PCD_RUN   = 2'b00,
    PCD_HOLD  = 2'b01,
    PCD_STOP  = 2'b11
  } pcd_state_e;
  typedef logic signed [5:0] pcd_delay_t;
endpackage

// File: pcd_pwm_ctrl.sv
`timescale 1ns/10ps
`include "pcd_defs.svh"
// Operation
// R1 - four delay registers at 0x11..0x14 for channels 1, 2, 1 inv, 2 inv
// R2 - delay equals bits 7..2 times four delay-clock cycles; zero means none
// R3 - delay field is signed, range -32 to +31 groups
// R4 - reset delays AC for odd channels and 54 for even channels
// R5 - host loads dual-phase delays before leaving shutdown
// R6 - with group enabled, grouped channels stay stopped on shutdown exit
// R7 - group mask bits 3..0 map channels 4..1, reset zero
// R8 - hold period starts on shutdown entry/exit and power-down change
// R9 - period bits 4..3 zero skip the 50 percent hold
// R10 - period code selects hold length, 01000 shortest, reset 01111
// R11 - hold duration only approximate
// R12 - bit 7 zero enables the start/stop timer, one disables it
// R13 - shutdown bit 6 clear runs outputs, set holds hard mute
// R14 - modulation select per channel comes from the input mux
module pcd_pwm_ctrl
  import pcd_pkg::*;
#(
  parameter int HOLD_UNIT_CYCLES = `PCD_HOLD_UNIT_US * `PCD_CLK_MHZ
) (
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        clk_en_in,
  input  wire logic        wr_en_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [7:0]  wr_data_in,
  output logic      [7:0]  rd_data_out,
  input  wire logic        power_down_input_in,
  input  wire logic [1:0]  dual_phase_modulation_in,
  input  wire logic        pwm_delay_clock_in,
  output logic      [3:0]  ch_run_out,
  output logic             half_duty_out,
  output logic             hard_mute_out,
  output logic [3:0][6:0]  delay_count_out,
  output logic [3:0]       delay_neg_out
);
  logic [3:0][7:0] delay_reg;
  logic [7:0]      sys_reg;
  logic [7:0]      group_reg;
  logic [7:0]      period_reg;
  logic [1:0]      pwrdn_sync_reg;
  logic            pwrdn_last_reg;
  logic [1:0]      pwm_delay_clock_sync_reg;
  logic            pwm_delay_clock_last_reg;
  logic            shut_last_reg;
  pcd_state_e      state_reg;
  pcd_state_e      state_next;
  logic [31:0]     hold_cnt_reg;
  logic [3:0]      run_reg;
  logic [17:0]     hold_tenths;

  // register decode
  wire logic       sel_delay  = (addr_in >= `PCD_OFS_DELAY_CH1) &&
                                (addr_in <= `PCD_OFS_DELAY_CH2_INV); // R1
  wire logic [1:0] delay_idx  = 2'(addr_in - `PCD_OFS_DELAY_CH1);
  wire logic       shut_cmd   = sys_reg[`PCD_SHUTDOWN_BIT];
  wire logic       group_on   = !sys_reg[`PCD_GROUP_EN_BIT];
  wire logic       timer_on   = !period_reg[`PCD_TIMER_OFF_BIT]; // R12
  wire logic [4:0] code       = period_reg[`PCD_PERIOD_MSB:0];
  wire logic       no_hold    = (code[4:3] == 2'b00); // R9
  wire logic       pwrdn_edge = pwrdn_sync_reg[1] ^ pwrdn_last_reg;
  wire logic       shut_edge  = shut_cmd ^ shut_last_reg;
  wire logic       trigger    = pwrdn_edge || shut_edge; // R8
  wire logic       pwm_delay_clock_rise  = pwm_delay_clock_sync_reg[1] && !pwm_delay_clock_last_reg;
  wire logic       dual_phase_any = |dual_phase_modulation_in; // R14
  // hold length in clocks; the table counts tenths of a millisecond
  wire logic [31:0] hold_len  = 32'(HOLD_UNIT_CYCLES) *
                                {14'h0000, hold_tenths}; // R10 R11

  // hold table; codes below 01000 never hold, so they read zero
  always_comb begin
    hold_tenths = 18'h00000;
    case (code)
      5'h08:   hold_tenths = `PCD_HOLD_08;
      5'h09:   hold_tenths = `PCD_HOLD_09;
      5'h0a:   hold_tenths = `PCD_HOLD_0A;
      5'h0b:   hold_tenths = `PCD_HOLD_0B;
      5'h0c:   hold_tenths = `PCD_HOLD_0C;
      5'h0d:   hold_tenths = `PCD_HOLD_0D;
      5'h0e:   hold_tenths = `PCD_HOLD_0E;
      5'h0f:   hold_tenths = `PCD_HOLD_0F;
      5'h10:   hold_tenths = `PCD_HOLD_10;
      5'h11:   hold_tenths = `PCD_HOLD_11;
      5'h12:   hold_tenths = `PCD_HOLD_12;
      5'h13:   hold_tenths = `PCD_HOLD_13;
      5'h14:   hold_tenths = `PCD_HOLD_14;
      5'h15:   hold_tenths = `PCD_HOLD_15;
      5'h16:   hold_tenths = `PCD_HOLD_16;
      5'h17:   hold_tenths = `PCD_HOLD_17;
      5'h18:   hold_tenths = `PCD_HOLD_18;
      5'h19:   hold_tenths = `PCD_HOLD_19;
      5'h1a:   hold_tenths = `PCD_HOLD_1A;
      5'h1b:   hold_tenths = `PCD_HOLD_1B;
      5'h1c:   hold_tenths = `PCD_HOLD_1C;
      5'h1d:   hold_tenths = `PCD_HOLD_1D;
      5'h1e:   hold_tenths = `PCD_HOLD_1E;
      5'h1f:   hold_tenths = `PCD_HOLD_1F;
      default: hold_tenths = 18'h00000;
    endcase
  end

  // read mux
  always_comb begin
    rd_data_out = 8'h00;
    if (sel_delay)
      rd_data_out = delay_reg[delay_idx];
    else if (addr_in == `PCD_OFS_SYS_CTRL)
      rd_data_out = sys_reg;
    else if (addr_in == `PCD_OFS_GROUP_MASK)
      rd_data_out = group_reg;
    else if (addr_in == `PCD_OFS_START_STOP)
      rd_data_out = period_reg;
  end

  // register writes
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      delay_reg[0] <= `PCD_RST_DELAY_ODD; // R4
      delay_reg[1] <= `PCD_RST_DELAY_EVEN;
      delay_reg[2] <= `PCD_RST_DELAY_ODD;
      delay_reg[3] <= `PCD_RST_DELAY_EVEN;
      sys_reg      <= `PCD_RST_SYS_CTRL;
      group_reg    <= `PCD_RST_GROUP_MASK; // R7
      period_reg   <= `PCD_RST_START_STOP; // R10
    end else if (clk_en_in && wr_en_in) begin
      if (sel_delay)
        delay_reg[delay_idx] <= {wr_data_in[7:2], 2'b00}; // R1
      else if (addr_in == `PCD_OFS_SYS_CTRL)
        sys_reg <= wr_data_in;
      else if (addr_in == `PCD_OFS_GROUP_MASK)
        group_reg <= {4'h3, wr_data_in[3:0]}; // R7
      else if (addr_in == `PCD_OFS_START_STOP)
        period_reg <= {wr_data_in[7], 2'b00, wr_data_in[4:0]};
    end
  end

  // pin synchronisers and edge memory
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pwrdn_sync_reg <= 2'b00;
      pwrdn_last_reg <= 1'b0;
      pwm_delay_clock_sync_reg <= 2'b00;
      pwm_delay_clock_last_reg <= 1'b0;
      shut_last_reg <= 1'b1;
    end else if (clk_en_in) begin
      pwrdn_sync_reg <= {pwrdn_sync_reg[0], power_down_input_in};
      pwrdn_last_reg <= pwrdn_sync_reg[1];
      pwm_delay_clock_sync_reg <= {pwm_delay_clock_sync_reg[0], pwm_delay_clock_in};
      pwm_delay_clock_last_reg <= pwm_delay_clock_sync_reg[1];
      shut_last_reg <= shut_cmd;
    end
  end

  // start/stop sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PCD_STOP:
        if (trigger && !shut_cmd)
          state_next = (timer_on && !no_hold) ? PCD_HOLD : PCD_RUN;
      PCD_RUN:
        if (trigger && timer_on && !no_hold)
          state_next = PCD_HOLD;
        else if (trigger && shut_cmd)
          state_next = PCD_STOP; // R13
      PCD_HOLD:
        if (hold_cnt_reg >= hold_len)
          state_next = shut_cmd ? PCD_STOP : PCD_RUN;
      default:
        state_next = PCD_STOP;
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg    <= PCD_STOP;
      hold_cnt_reg <= 32'h0;
      run_reg      <= 4'h0;
    end else if (clk_en_in) begin
      state_reg    <= state_next;
      hold_cnt_reg <= (state_reg == PCD_HOLD) ? hold_cnt_reg + 32'h1 : 32'h0;
      if (state_next == PCD_RUN && state_reg != PCD_RUN)
        run_reg <= group_on ? ~group_reg[3:0] : 4'hf; // R6
      else if (state_next == PCD_STOP)
        run_reg <= 4'h0;
    end
  end

  assign ch_run_out    = run_reg;
  assign half_duty_out = (state_reg == PCD_HOLD); // R8
  assign hard_mute_out = (state_reg == PCD_STOP); // R13

  // per-channel counts of delay-clock rises since the outputs started
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_delay
      pcd_delay_t amt;
      logic [6:0] cnt_reg;
      assign amt = delay_reg[g][`PCD_DELAY_MSB:`PCD_DELAY_LSB]; // R3
      always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in)
          cnt_reg <= 7'h00;
        else if (clk_en_in && state_reg != PCD_RUN)
          cnt_reg <= 7'h00;
        else if (clk_en_in && pwm_delay_clock_rise && cnt_reg != 7'h7f)
          cnt_reg <= cnt_reg + 7'h01; // R2
      end
      assign delay_count_out[g] = cnt_reg;
      assign delay_neg_out[g]   = amt[5];
      chk_delay_step: assert property (@(posedge clk_in) // R2
        disable iff (!reset_n_in)
        (clk_en_in && state_reg == PCD_RUN && pwm_delay_clock_rise && cnt_reg != 7'h7f)
          |=> cnt_reg == $past(cnt_reg) + 7'h01)
        else $error("delay count missed a step");
    end
  endgenerate

  chk_mute_shut: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (clk_en_in && shut_cmd && state_reg != PCD_HOLD)
      |=> state_reg != PCD_RUN) // R13
    else $error("running while shutdown set");
  chk_skip_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (clk_en_in && trigger && no_hold && state_reg != PCD_HOLD)
      |=> state_reg != PCD_HOLD) // R9
    else $error("hold entered with zero code");
  chk_timer_off: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (clk_en_in && !timer_on && state_reg != PCD_HOLD)
      |=> state_reg != PCD_HOLD) // R12
    else $error("hold entered with timer off");
  chk_group_stop: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (clk_en_in && group_on && state_next == PCD_RUN && state_reg != PCD_RUN)
      |=> (ch_run_out & $past(group_reg[3:0])) == 4'h0) // R6
    else $error("grouped channel running");
  chk_hold_start: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (clk_en_in && trigger && timer_on && !no_hold && state_reg != PCD_HOLD
      && (state_reg == PCD_RUN || !shut_cmd))
      |=> half_duty_out) // R8
    else $error("no hold after trigger");
  chk_run_stop: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    hard_mute_out |-> ch_run_out == 4'h0) // R13
    else $error("channel runs in mute");
  chk_reset_dly: assert property (@(posedge clk_in)
    $rose(reset_n_in) |-> delay_reg[0] == `PCD_RST_DELAY_ODD) // R4
    else $error("bad delay reset");
  chk_cnt_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (clk_en_in && state_reg != PCD_RUN) |=> delay_count_out[0] == 7'h00) // R2
    else $error("delay count not cleared");

  cov_hold: cover property (@(posedge clk_in) state_reg == PCD_HOLD);
  cov_run: cover property (@(posedge clk_in) state_reg == PCD_RUN);
  cov_pwrdn: cover property (@(posedge clk_in) pwrdn_edge);
  cov_dual_run: cover property (@(posedge clk_in)
    dual_phase_any && state_reg == PCD_RUN); // R14
endmodule

// File: pcd_pwm_ctrl_tb.sv
`timescale 1ns/10ps
module pcd_pwm_ctrl_tb
  import pcd_pkg::*;
;
  logic            clk_in = 0;
  logic            reset_n_in = 0;
  logic            wr_en_in = 0;
  logic [7:0]      addr_in = 8'h00;
  logic [7:0]      wr_data_in = 8'h00;
  logic            power_down_input_in = 0;
  logic            pwm_delay_clock_in = 0;
  logic            clk_en_in = 1;
  logic [1:0]      dual_phase_modulation_in = 2'h0;
  logic [7:0]      rd_data_out;
  logic [3:0]      ch_run_out;
  logic            half_duty_out;
  logic            hard_mute_out;
  logic [3:0][6:0] delay_count_out;
  logic [3:0]      delay_neg_out;
  logic [7:0]      dual_val [4] = '{8'hb8, 8'h60, 8'ha0, 8'h48};
  int              fails = 0;
  int              checks_done = 0;
  // 40 MHz system clock and a slower unrelated delay clock
  always #12.5 clk_in = ~clk_in;
  always #55 pwm_delay_clock_in = ~pwm_delay_clock_in;
  pcd_pwm_ctrl #(.HOLD_UNIT_CYCLES(2)) pcd_pwm_ctrl_i (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
    .wr_en_in(wr_en_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .rd_data_out(rd_data_out), .power_down_input_in(power_down_input_in),
    .dual_phase_modulation_in(dual_phase_modulation_in),
    .pwm_delay_clock_in(pwm_delay_clock_in), .ch_run_out(ch_run_out),
    .half_duty_out(half_duty_out), .hard_mute_out(hard_mute_out),
    .delay_count_out(delay_count_out), .delay_neg_out(delay_neg_out));
  // verdict and end of run
  task wrap_up;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one-cycle write strobe, driven just after the edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #2;
    addr_in = a;
    wr_data_in = d;
    wr_en_in = 1;
    @(posedge clk_in);
    #2;
    wr_en_in = 0;
  endtask
  // combinational read of the addressed register
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    #2;
    addr_in = a;
    #5;
    cmp(rd_data_out, exp, "read");
  endtask
  // bounded wait for the 50 percent hold flag to reach a level
  task wait_hd(input logic lvl, input int bound);
    int n;
    n = 0;
    while (half_duty_out !== lvl && n < bound) begin
      @(posedge clk_in);
      #2;
      n++;
    end
    checks_done++;
    if (n >= bound) begin
      fails++;
      $display("mismatch at %0t: hold flag wait ran out", $time);
      wrap_up();
    end
  endtask
  // the hold flag must stay low for the whole stretch
  task quiet(input int cyc);
    int hi;
    hi = 0;
    repeat (cyc) begin
      @(posedge clk_in);
      #2;
      if (half_duty_out !== 1'b0) hi++;
    end
    cmp(hi[7:0], 8'h00, "unexpected hold");
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge clk_in);
    #2;
    reset_n_in = 1;
    cmp({7'h00, hard_mute_out}, 8'h01, "mute after reset");
    cmp({1'b0, delay_count_out[0]}, 8'h00, "count idle");
    rd(8'h11, 8'hac);
    rd(8'h12, 8'h54);
    rd(8'h13, 8'hac);
    rd(8'h14, 8'h54);
    rd(8'h19, 8'h30);
    rd(8'h1a, 8'h0f);
    rd(8'h15, 8'h00);
    // a write while the clock enable is low must not land
    @(posedge clk_in);
    #2;
    clk_en_in = 0;
    dual_phase_modulation_in = 2'h3;
    wr(8'h11, 8'h00);
    clk_en_in = 1;
    rd(8'h11, 8'hac);
    wr(8'h11, 8'h7f);
    rd(8'h11, 8'h7c);
    wr(8'h12, 8'h80);
    rd(8'h12, 8'h80);
    cmp({4'h0, delay_neg_out}, 8'h06, "delay sign");
    for (int i = 0; i < 4; i++) wr(8'h11 + i[7:0], dual_val[i]);
    for (int i = 0; i < 4; i++) rd(8'h11 + i[7:0], dual_val[i]);
    wr(8'h19, 8'h05);
    rd(8'h19, 8'h35);
    wr(8'h1a, 8'h08);
    wr(8'h05, 8'h00);
    wait_hd(1'b1, 10);
    wait_hd(1'b0, 20000);
    cmp({4'h0, ch_run_out}, 8'h0a, "group run");
    cmp({7'h00, hard_mute_out}, 8'h00, "mute released");
    power_down_input_in = 1;
    wait_hd(1'b1, 10);
    wait_hd(1'b0, 20000);
    wr(8'h1a, 8'h00);
    wr(8'h05, 8'h40);
    quiet(30);
    cmp({7'h00, hard_mute_out}, 8'h01, "mute on shutdown");
    wr(8'h1a, 8'h88);
    wr(8'h05, 8'h20);
    quiet(30);
    cmp({4'h0, ch_run_out}, 8'h0f, "group off run");
    cmp({7'h00, hard_mute_out}, 8'h00, "mute off");
    // long run: every delay-clock rise is counted until saturation
    repeat (600) @(posedge clk_in);
    #2;
    cmp({1'b0, delay_count_out[0]}, 8'h7f, "count full");
    // second reset in mid-run restores the defaults
    reset_n_in = 0;
    repeat (2) @(posedge clk_in);
    #2;
    reset_n_in = 1;
    cmp({7'h00, hard_mute_out}, 8'h01, "mute after reset");
    rd(8'h11, 8'hac);
    wrap_up();
  end
endmodule
